// [rtl/sram_burst_regs.svh]
// Purpose: Shared constants of the pipelined burst SRAM access block
// Assumes: Included by bare name from each file that uses its macros
// Notes:   Definitions only
`ifndef SRAM_BURST_REGS_SVH
`define SRAM_BURST_REGS_SVH

// =====================================================================
// Array geometry
`define ADDR_W      17
`define WORDS       131072
`define DATA_W      32
`define LANES       4
`define LANE_W      9
`define ALL_LANES   4'hF
`define NO_LANES    4'h0

// =====================================================================
// Burst counter and buffering
`define STEP_W      2
`define BUF_DEPTH   2
`define ENTRY_W     57

`endif

// [rtl/sram_burst_pkg.sv]
// Purpose: Types of the pipelined burst SRAM access block
// Assumes: Nothing imported; users write sram_burst_pkg::name
// Notes:   Constants live in sram_burst_regs.svh
package sram_burst_pkg;

    // =================================================================
    // Access state: deselected or inside an access or burst
    typedef enum logic {ST_IDLE, ST_ACTIVE} accState_e;

    // Array word address
    typedef logic [16:0] sramAddr_t;

endpackage : sram_burst_pkg

// [rtl/burst_counter.sv]
// Purpose: Two-bit wraparound burst counter, linear or interleaved
// Assumes: Load and step are never asserted in the same cycle
// Notes:   Counts steps, then maps them through the selected order
`timescale 1ns/10ps
`include "sram_burst_regs.svh"

module burst_counter (
    input  wire logic               mclk,
    input  wire logic               rst_b,
    input  wire logic               load,
    input  wire logic [`STEP_W-1:0] startBits,
    input  wire logic               step,
    input  wire logic               interleaved,
    output logic      [`STEP_W-1:0] count,
    output logic      [`STEP_W-1:0] countNext
);

    logic [`STEP_W-1:0] startFf;  // First address bits of the burst
    logic [`STEP_W-1:0] stepFf;   // Steps taken since the load
    logic [`STEP_W-1:0] stepInc;  // Step count after one more advance

    // =================================================================
    // Step counter; wraps after four addresses
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            startFf <= 2'h0;
            stepFf  <= 2'h0;
        end
        else if (load)
        begin
            startFf <= startBits;   // [RQ3]
            stepFf  <= 2'h0;
        end
        else if (step)
        begin
            stepFf <= stepInc;      // [RQ4]
        end
    end

    assign stepInc = stepFf + 2'h1;

    // =================================================================
    // Order mapping: interleaved XORs, linear adds with wrap
    always_comb
    begin
        if (interleaved)
        begin
            count     = startFf ^ stepFf;    // [RQ22]
            countNext = startFf ^ stepInc;   // [RQ22]
        end
        else
        begin
            count     = startFf + stepFf;    // [RQ23]
            countNext = startFf + stepInc;   // [RQ23]
        end
    end

endmodule : burst_counter

// [rtl/two_entry_buffer.sv]
// Purpose: Small ring buffer with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Full and empty come from an occupancy count
`timescale 1ns/10ps

module two_entry_buffer #(
    parameter int WIDTH = 57,
    parameter int DEPTH = 2
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] slotFf [DEPTH];   // Storage slots
    logic [PW-1:0]    wrPtrFf;          // Next slot to fill
    logic [PW-1:0]    rdPtrFf;          // Oldest slot
    logic [PW:0]      fillFf;           // Occupancy
    logic             push;
    logic             pop;

    assign inReady  = (fillFf != (PW+1)'(DEPTH));
    assign outValid = (fillFf != '0);
    assign outData  = slotFf[rdPtrFf];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // =================================================================
    // Slot storage; data needs no reset
    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            slotFf[wrPtrFf] <= inData;
        end
    end

    // =================================================================
    // Pointers and occupancy
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrPtrFf <= '0;
            rdPtrFf <= '0;
            fillFf  <= '0;
        end
        else
        begin
            if (push)
            begin
                wrPtrFf <= wrPtrFf + PW'(1);
            end
            if (pop)
            begin
                rdPtrFf <= rdPtrFf + PW'(1);
            end
            if (push && !pop)
            begin
                fillFf <= fillFf + (PW+1)'(1);
            end
            else if (pop && !push)
            begin
                fillFf <= fillFf - (PW+1)'(1);
            end
        end
    end

endmodule : two_entry_buffer

// [rtl/pipelined_burst_sram_access.sv]
// Purpose: Access logic of a 128K x 36 pipelined burst SRAM
// Assumes: Bus pins are synchronous to mclk; strap and sleep are not
// Notes:   Output enable gates the drivers without a clock
//
// Operation
// (RQ1) Inputs sampled, read data registered, rising edge
// (RQ2) Strap low linear, high interleaved, held static
// (RQ3) Access start loads low address bits into counter
// (RQ4) Advance low during burst steps the counter
// (RQ5) Processor strobe ignored while first select high
// (RQ6) Read starts: strobe, selects active, writes high
// (RQ7) Start address held and presented to array
// (RQ8) Read data appears after next rising edge
// (RQ9) Outputs off first cycle leaving deselected state
// (RQ10) Back-to-back reads; deselect turns outputs off
// (RQ11) Processor start ignores write and advance inputs
// (RQ12) Processor write completes at second edge
// (RQ13) Byte write needs lane select and gate low
// (RQ14) Unselected lanes keep data and parity
// (RQ15) Global write overrides, stores all four lanes
// (RQ16) Controller raises output enable before writing
// (RQ17) Drivers off whenever a write is seen
// (RQ18) Controller strobe write completes in one clock
// (RQ19) Controller start ignores the advance input
// (RQ20) Bursts work for both reads and writes
// (RQ21) Both strobes low: processor strobe wins
// (RQ22) Interleaved: start XOR step count
// (RQ23) Linear: start plus step, wrapping
`timescale 1ns/10ps
`include "sram_burst_regs.svh"

module pipelined_burst_sram_access (
    input  wire logic                mclk,
    input  wire logic                rst_b,
    input  wire logic [`ADDR_W-1:0]  addr,
    input  wire logic                proc_addr_strobe_n,
    input  wire logic                ctrl_addr_strobe_n,
    input  wire logic                burst_step_n,
    input  wire logic                all_bytes_write_n,
    input  wire logic                lane_write_gate_n,
    input  wire logic [`LANES-1:0]   lane_select_n,
    input  wire logic                chip_sel_a_n,
    input  wire logic                chip_sel_b,
    input  wire logic                chip_sel_c_n,
    input  wire logic                outEnableN,
    input  wire logic                modeInterleaved,
    input  wire logic                sleep_request,
    input  wire logic [`DATA_W-1:0]  dqIn,
    output logic      [`DATA_W-1:0]  dqOut,
    output logic                     dqOe,
    input  wire logic [`LANES-1:0]   parity_lines_in,
    output logic      [`LANES-1:0]   parity_lines_out,
    output logic                     parityOe,
    output logic                     writeReady
);

    // =================================================================
    // Declarations
    sram_burst_pkg::accState_e stateFf;     // Access state
    sram_burst_pkg::sramAddr_t addrFf;      // Address register
    sram_burst_pkg::sramAddr_t usedAddr;    // Used address
    sram_burst_pkg::sramAddr_t addrUsedFf;  // Array address
    logic                rdPendFf;    // Read in flight
    logic                outValidFf;  // Output live
    logic [`DATA_W-1:0]  rdData;      // Array word
    logic [`LANES-1:0]   rdPar;       // Array parity
    logic [1:0]          modeSyncFf;  // Strap synchroniser
    logic [1:0]          sleepSyncFf; // Sleep request synchroniser
    logic                procRec;     // Processor start
    logic                ctrlRec;     // Controller start
    logic                startAny;    // Some strobe recognised
    logic                selAll;      // All three selects active
    logic                startSel;    // Access begins at this edge
    logic                deselNow;    // Deselect edge
    logic                contCycle;   // Burst cycle
    logic                advance;     // Counter steps at this edge
    logic [`LANES-1:0]   lanesReq;    // Lanes to write
    logic                wrNow;       // Write edge
    logic                rdNow;       // Read edge
    logic [1:0]          cnt;         // Current burst low bits
    logic [1:0]          cntNext;     // Low bits after one step
    logic [1:0]          usedLow;     // Low bits used this cycle
    logic [`ENTRY_W-1:0] entryIn;     // Write entry into the buffer
    logic [`ENTRY_W-1:0] entryOut;    // Oldest write
    logic                headValid;   // Write waiting
    logic                drainReady;  // Array accepts a write
    logic                drainFire;   // A write enters the array now
    logic                bufReady;    // Buffer has room

    // =================================================================
    // Strap and sleep are asynchronous: two flops each
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            modeSyncFf  <= 2'h3;   // Strap defaults to interleaved
            sleepSyncFf <= 2'h0;
        end
        else
        begin
            modeSyncFf  <= {modeSyncFf[0], modeInterleaved};   // [RQ2]
            sleepSyncFf <= {sleepSyncFf[0], sleep_request};
        end
    end

    // =================================================================
    // Cycle decode of the pins sampled at this edge
    assign selAll   = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
    // Processor strobe needs first select low
    assign procRec  = !proc_addr_strobe_n && !chip_sel_a_n;   // [RQ5]
    assign ctrlRec  = !ctrl_addr_strobe_n && !procRec;        // [RQ21]
    assign startAny = procRec || ctrlRec;
    assign startSel = startAny && selAll;
    assign deselNow = startAny && !selAll;
    assign contCycle = !startAny && (stateFf == sram_burst_pkg::ST_ACTIVE);
    // Advance ignored on any start edge
    assign advance  = contCycle && !burst_step_n;   // [RQ4] [RQ11] [RQ19]

    // Global write overrides gate and lane selects
    always_comb
    begin
        if (!all_bytes_write_n)
        begin
            lanesReq = `ALL_LANES;                  // [RQ15]
        end
        else if (!lane_write_gate_n)
        begin
            lanesReq = ~lane_select_n;              // [RQ13]
        end
        else
        begin
            lanesReq = `NO_LANES;
        end
    end

    // Processor start never writes; write follows
    assign wrNow = (lanesReq != `NO_LANES)
                && ((ctrlRec && selAll) || contCycle);  // [RQ11] [RQ12] [RQ18]
    assign rdNow = (startSel || contCycle) && !wrNow;   // [RQ6] [RQ20]

    // Start uses pins; later cycles the counter
    assign usedLow  = startSel ? addr[1:0] : (advance ? cntNext : cnt);
    assign usedAddr = startSel ? addr : {addrFf[`ADDR_W-1:2], usedLow}; // [RQ7]

    // =================================================================
    // Burst counter
    burst_counter u_burst (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .load        (startSel),
        .startBits   (addr[1:0]),
        .step        (advance),
        .interleaved (modeSyncFf[1]),
        .count       (cnt),
        .countNext   (cntNext)
    );

    // =================================================================
    // Address register and access state
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stateFf <= sram_burst_pkg::ST_IDLE;
            addrFf  <= '0;
        end
        else if (deselNow)
        begin
            stateFf <= sram_burst_pkg::ST_IDLE;
        end
        else if (startSel)
        begin
            stateFf <= sram_burst_pkg::ST_ACTIVE;
            addrFf  <= addr;                        // [RQ7]
        end
    end

    // =================================================================
    // Read pipeline: address now, output next edge
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdPendFf   <= 1'b0;
            addrUsedFf <= '0;
        end
        else
        begin
            rdPendFf   <= rdNow;                    // [RQ1]
            addrUsedFf <= usedAddr;
        end
    end

    // Output register and its live flag
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            outValidFf       <= 1'b0;
            dqOut            <= '0;
            parity_lines_out <= '0;
        end
        else
        begin
            if (rdPendFf)
            begin
                dqOut            <= rdData;         // [RQ1] [RQ8]
                parity_lines_out <= rdPar;
            end
            if (deselNow)
            begin
                outValidFf <= 1'b0;                 // [RQ10]
            end
            else if (wrNow)
            begin
                outValidFf <= 1'b0;                 // [RQ17]
            end
            else
            begin
                // From deselect no read is pending: stays off
                outValidFf <= rdPendFf;             // [RQ9] [RQ10]
            end
        end
    end

    // Output enable gates drivers without clock
    assign dqOe     = outValidFf && !outEnableN;    // [RQ8] [RQ16]
    assign parityOe = dqOe;

    // =================================================================
    // Write path: two-entry buffer before the array port.
    // Sleep stalls the drain so the array holds;
    // sleep recovery idle lets the buffer empty.
    assign entryIn    = {usedAddr, parity_lines_in, dqIn, lanesReq};
    assign drainReady = !sleepSyncFf[1];
    assign drainFire  = headValid && drainReady;

    two_entry_buffer #(
        .WIDTH (`ENTRY_W),
        .DEPTH (`BUF_DEPTH)
    ) u_wbuf (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .inValid  (wrNow),
        .inReady  (bufReady),
        .inData   (entryIn),
        .outValid (headValid),
        .outReady (drainReady),
        .outData  (entryOut)
    );

    assign writeReady = bufReady;

    // =================================================================
    // Array: one memory per lane, byte plus parity
    for (genvar g = 0; g < `LANES; g++)
    begin : g_lane
        logic [`LANE_W-1:0] laneMem [`WORDS];   // Byte and parity

        // Only lanes flagged in the entry change
        always_ff @(posedge mclk)
        begin
            if (drainFire && entryOut[g])           // [RQ14]
            begin
                laneMem[entryOut[56:40]] <= {entryOut[36+g],
                                             entryOut[4+8*g +: 8]};
            end
        end

        assign rdData[8*g +: 8] = laneMem[addrUsedFf][7:0];
        assign rdPar[g]         = laneMem[addrUsedFf][8];
    end

    // =================================================================
    // Checks
    sequence s_procStartSel;
        procRec && selAll;
    endsequence

    sequence s_secondGlobal;
        ##1 (proc_addr_strobe_n && ctrl_addr_strobe_n
             && !all_bytes_write_n);
    endsequence

    property p_readOut;
        @(posedge mclk) disable iff (!rst_b)
        rdNow ##1 rdPendFf |=> (dqOut == $past(rdData));
    endproperty
    a_readOut: assert property (p_readOut)   // [RQ8]
        else $error("read data wrong");

    property p_emergeOff;
        @(posedge mclk) disable iff (!rst_b)
        (stateFf == sram_burst_pkg::ST_IDLE) && startSel |=> !dqOe;
    endproperty
    a_emergeOff: assert property (p_emergeOff)   // [RQ9]
        else $error("first cycle driven");

    property p_deselOff;
        @(posedge mclk) disable iff (!rst_b)
        deselNow |=> !dqOe && !parityOe;
    endproperty
    a_deselOff: assert property (p_deselOff)   // [RQ10]
        else $error("driven after deselect");

    property p_writeOff;
        @(posedge mclk) disable iff (!rst_b)
        wrNow |=> !dqOe;
    endproperty
    a_writeOff: assert property (p_writeOff)   // [RQ17]
        else $error("driven after write");

    property p_procNoWrite;
        @(posedge mclk) disable iff (!rst_b)
        procRec |-> !wrNow && !advance;
    endproperty
    a_procNoWrite: assert property (p_procNoWrite)   // [RQ11]
        else $error("processor start wrote");

    property p_ceGate;
        @(posedge mclk) disable iff (!rst_b)
        chip_sel_a_n && ctrl_addr_strobe_n |-> !startAny;
    endproperty
    a_ceGate: assert property (p_ceGate)   // [RQ5]
        else $error("strobe taken, select high");

    property p_procWrite;
        @(posedge mclk) disable iff (!rst_b)
        s_procStartSel ##0 s_secondGlobal |->
            wrNow && (lanesReq == `ALL_LANES)
            && (usedAddr[`ADDR_W-1:2] == $past(addr[`ADDR_W-1:2]));
    endproperty
    a_procWrite: assert property (p_procWrite)   // [RQ12]
        else $error("processor write missed");

    property p_ctrlWrite;
        @(posedge mclk) disable iff (!rst_b)
        ctrlRec && selAll && !all_bytes_write_n |->
            wrNow && (entryIn[`ENTRY_W-1:40] == addr);
    endproperty
    a_ctrlWrite: assert property (p_ctrlWrite)   // [RQ18]
        else $error("controller write missed");

    property p_laneOnly;
        @(posedge mclk) disable iff (!rst_b)
        wrNow && all_bytes_write_n |->
            !lane_write_gate_n && (lanesReq == ~lane_select_n);
    endproperty
    a_laneOnly: assert property (p_laneOnly)   // [RQ13]
        else $error("byte write lanes wrong");

    property p_loadStart;
        @(posedge mclk) disable iff (!rst_b)
        startSel |=> (cnt == $past(addr[1:0]));
    endproperty
    a_loadStart: assert property (p_loadStart)   // [RQ3]
        else $error("counter not loaded");

    property p_linStep;
        @(posedge mclk) disable iff (!rst_b)
        advance && !modeSyncFf[1] |=> (cnt == $past(cnt) + 2'h1);
    endproperty
    a_linStep: assert property (p_linStep)   // [RQ23]
        else $error("linear step wrong");

endmodule : pipelined_burst_sram_access

// [dv/sram_bus_model.sv]
// Purpose: Bus controller model for the burst SRAM
// Assumes: Pins move only after the falling edge of mclk
// Notes:   Released lines show the inverse of the last word
`timescale 1ns/10ps
`include "sram_burst_regs.svh"

module sram_bus_model (
    input  wire logic               mclk,
    input  wire logic [`DATA_W-1:0] dqOut,
    input  wire logic               dqOe,
    input  wire logic [`LANES-1:0]  parity_lines_out,
    input  wire logic               parityOe,
    output logic      [`ADDR_W-1:0] addr,
    output logic                    proc_addr_strobe_n,
    output logic                    ctrl_addr_strobe_n,
    output logic                    burst_step_n,
    output logic                    all_bytes_write_n,
    output logic                    lane_write_gate_n,
    output logic      [`LANES-1:0]  lane_select_n,
    output logic                    chip_sel_a_n,
    output logic                    chip_sel_b,
    output logic                    chip_sel_c_n,
    output logic                    outEnableN,
    output logic      [`DATA_W-1:0] dqIn,
    output logic      [`LANES-1:0]  parity_lines_in
);
    // ================================================================
    // Shared line level
    logic [35:0] word;  // Last word the model drove
    logic        drv;   // Model drives the lines now

    // Stale word flipped: a missed write cannot match
    assign dqIn = dqOe ? dqOut : drv ? word[31:0] : ~word[31:0];
    assign parity_lines_in = parityOe ? parity_lines_out
                           : drv ? word[35:32] : ~word[35:32];

    // ================================================================
    // Bus cycle: ctl is {proc, ctrl, step, global, gate}, low active
    task automatic put(input logic [4:0] ctl, input logic [3:0] bw,
                       input logic [1:0] sel, input logic [16:0] a,
                       input logic [35:0] wd, input logic d);
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n,
         all_bytes_write_n, lane_write_gate_n} = ctl;
        lane_select_n = bw;
        chip_sel_a_n  = !sel[0];
        chip_sel_b    = sel[1];
        chip_sel_c_n  = !sel[1];
        addr          = a;
        outEnableN    = d;  // Output enable high while driving
        drv           = d;
        word          = d ? wd : word;
    endtask : put

    task automatic cyc(input logic [4:0] ctl, input logic [3:0] bw,
                       input logic [1:0] sel, input logic [16:0] a,
                       input logic [35:0] wd, input logic d);
        @(negedge mclk);
        put(ctl, bw, sel, a, wd, d);
    endtask : cyc

    // Idle from time zero
    initial
    begin
        word = '0;
        put(5'h1F, 4'hF, 2'h0, '0, '0, 1'b0);
    end
endmodule : sram_bus_model

// [dv/tb_top.sv]
// Purpose: Self-checking bench of the burst SRAM access block
// Assumes: sram_bus_model makes every bus cycle
// Notes:   shadow mirrors stored words
`timescale 1ns/10ps
`include "sram_burst_regs.svh"

module tb_top;
    // ================================================================
    // Pins and bookkeeping
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic modeInterleaved = 1'b1;
    logic sleep_request = 1'b0;
    logic [16:0] addr;
    logic proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n;
    logic all_bytes_write_n, lane_write_gate_n, outEnableN;
    logic chip_sel_a_n, chip_sel_b, chip_sel_c_n, dqOe, parityOe;
    logic writeReady;
    logic [3:0] lane_select_n, parity_lines_in, parity_lines_out;
    logic [31:0] dqIn, dqOut;
    logic [35:0] shadow [int];  // Words the array should hold
    int fail_count = 0;
    int tests_run = 0;

    always #10 mclk = ~mclk;  // 50 MHz

    pipelined_burst_sram_access dut (.*);
    sram_bus_model bm (.*);

    // ================================================================
    // Compares and helpers
    task automatic chk_word(input logic [35:0] e);
        tests_run++;
        if ({parity_lines_out, dqOut} !== e)
        begin
            fail_count++;
            $display("[FAIL] %0t exp %h got %h", $time, e,
                     {parity_lines_out, dqOut});
        end
    endtask : chk_word

    task automatic chk_bit(input logic e, input logic g);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask : chk_bit

    // Sample once outputs settle
    task automatic tick;
        @(posedge mclk);
        #5;
    endtask : tick

    function automatic logic [35:0] merge(input logic [35:0] o, n,
                                          input logic [3:0] l);
        merge = o;
        for (int g = 0; g < 4; g++)
        begin
            if (!l[g])
            begin
                merge[8*g +: 8] = n[8*g +: 8];
                merge[32+g]     = n[32+g];
            end
        end
    endfunction : merge

    task automatic idle(input int n);
        repeat (n) bm.cyc(5'h1F, 4'hF, 2'h0, '0, '0, 1'b0);
    endtask : idle

    // Strap settles two edges after release
    task automatic do_reset;
        rst_b = 1'b0;
        repeat (12) @(negedge mclk);
        rst_b = 1'b1;
        idle(3);
    endtask : do_reset

    task automatic wr(input logic [16:0] a, input logic [35:0] d);
        bm.cyc(5'h15, 4'hF, 2'h3, a, d, 1'b1);
        shadow[a] = d;
    endtask : wr

    task automatic desel;
        bm.cyc(5'h0F, 4'hF, 2'h1, '0, '0, 1'b0);
    endtask : desel

    task automatic rd(input logic [16:0] a);
        bm.cyc(5'h0F, 4'hF, 2'h3, a, '0, 1'b0);
        idle(1);
        tick();
        chk_word(shadow[a]);
    endtask : rd

    // ================================================================
    // Scenarios
    task automatic t_global;
        wr(17'h00010, 36'h9_A5A5_5A5A);
        tick();
        chk_bit(1'b0, dqOe | parityOe);
        desel();
        bm.cyc(5'h0F, 4'hF, 2'h3, 17'h00010, '0, 1'b0);
        tick();
        chk_bit(1'b0, dqOe);
        idle(1);
        tick();
        chk_word(shadow[17'h00010]);
        chk_bit(1'b1, dqOe);
    endtask : t_global

    task automatic t_lanes;
        logic [3:0]  ln [4] = '{4'hA, 4'h5, 4'h0, 4'hE};
        logic [4:0]  op [4] = '{5'h1E, 5'h1E, 5'h1F, 5'h1E};
        logic [35:0] d;
        wr(17'h00020, 36'h6_1234_5678);
        for (int i = 0; i < 4; i++)
        begin
            d = {i[3:0] ^ 4'h9, 32'h5EC0_0D00 + 32'(i)};
            bm.cyc(5'h00, 4'h0, 2'h3, 17'h00020, '0, 1'b0);
            bm.cyc(op[i], ln[i], 2'h3, 17'h1FFFF, d, 1'b1);
            if (op[i] == 5'h1E)
                shadow[17'h00020] = merge(shadow[17'h00020], d, ln[i]);
            desel();
            rd(17'h00020);
        end
    endtask : t_lanes

    task automatic t_desel;
        desel();
        bm.cyc(5'h0F, 4'hF, 2'h3, 17'h00010, '0, 1'b0);
        bm.cyc(5'h0F, 4'hF, 2'h3, 17'h00020, '0, 1'b0);
        tick();
        chk_word(shadow[17'h00010]);
        bm.cyc(5'h0F, 4'hF, 2'h2, 17'h00030, '0, 1'b0);
        tick();
        chk_word(shadow[17'h00020]);
        chk_bit(1'b1, dqOe);
        idle(1);
        tick();
        chk_word(shadow[17'h00020]);
        desel();
        tick();
        chk_bit(1'b0, dqOe);
    endtask : t_desel

    task automatic t_both;
        bm.cyc(5'h05, 4'hF, 2'h3, 17'h00010, 36'hF_FFFF_0000, 1'b1);
        idle(1);
        tick();
        chk_word(shadow[17'h00010]);
    endtask : t_both

    task automatic t_burst(input logic il);
        logic [1:0] o;
        logic [1:0] j;
        modeInterleaved = il;  // Strap moves only under reset
        do_reset();
        for (int k = 0; k < 4; k++)
        begin
            o = il ? 2'h1 ^ k[1:0] : 2'h1 + k[1:0];
            shadow[{15'h0040, o}] = {4'h3, 29'h0, il, k[1:0]};
            bm.cyc(k ? 5'h19 : 5'h11, 4'hF, 2'h3, 17'h00101,
                   shadow[{15'h0040, o}], 1'b1);
        end
        for (int k = 0; k < 5; k++)
        begin
            bm.cyc(k ? 5'h1B : 5'h13, 4'hF, 2'h3, 17'h00102, '0, 1'b0);
            j = k[1:0] - 2'h1;
            o = il ? 2'h2 ^ j : 2'h2 + j;
            if (k > 0)
            begin
                tick();
                chk_word(shadow[{15'h0040, o}]);
            end
        end
    endtask : t_burst

    // Sleep stalls the drain; both entries stay
    task automatic t_sleep;
        desel();
        sleep_request = 1'b1;
        idle(3);
        wr(17'h00030, 36'h1_2345_6789);
        wr(17'h00031, 36'hE_DCBA_9876);
        tick();
        chk_bit(1'b0, writeReady);
        desel();
        sleep_request = 1'b0;
        idle(6);
        tick();
        chk_bit(1'b1, writeReady);
        rd(17'h00030);
        rd(17'h00031);
    endtask : t_sleep

    // ================================================================
    // Verdict, sequence and watchdog
    task automatic finish_test;
        if (fail_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    initial
    begin
        do_reset();
        t_global();
        t_lanes();
        t_desel();
        t_both();
        t_burst(1'b1);
        t_burst(1'b0);
        t_sleep();
        finish_test();
    end

    // Nearly ninety times the needed run
    initial
    begin
        #200000;
        fail_count++;
        finish_test();
    end
endmodule : tb_top
